// *** smcc_ctrl.v ***
// conversion sequencer, result registers and apb slave of the shunt monitor
`timescale 1ns/1ps
`default_nettype none
`include "smcc_consts.vh"
module smcc_ctrl #(
   parameter RECOVER_CYC = `SMCC_RECOVER_CYC
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   input  wire          convert_pin,
   input  wire          smp_valid,
   input  wire [15:0]   smp_shunt,
   input  wire [15:0]   smp_bus,
   output reg           smp_req_shunt,
   output reg           smp_req_bus,
   output reg  [1:0]    shunt_gain_sel,
   output reg           bus_range_sel,
   output reg           conversion_ready_flag,
   output reg           adc_power_on
);
   // ---------------------------------------------------------
   // sequencer states, one-hot
   // ---------------------------------------------------------
   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_SHUNT = 6'h02;
   localparam [5:0] ST_BUS   = 6'h04;
   localparam [5:0] ST_MATH1 = 6'h08;
   localparam [5:0] ST_MATH2 = 6'h10;
   localparam [5:0] ST_WAKE  = 6'h20;
   // last count of the settle wait; the counter is sized for the default
   localparam [12:0] WAKE_LAST = RECOVER_CYC - 1;

   reg  [15:0] config_reg;
   reg  [15:0] calib;
   reg  [15:0] shunt_res;
   reg  [15:0] bus_res;
   reg  [15:0] current_res;
   reg  [15:0] power_res;
   reg         math_ovf;
   reg  [5:0]  state;
   reg  [12:0] wake_cnt;
   reg         shot_pending;
   reg         conv_sync1;
   reg         conv_sync2;
   reg         conv_last;
   reg  [15:0] cur_prod_hold;
   reg         avg_start_sh;
   reg         avg_start_bus;
   wire        sh_done;
   wire        bus_done;
   wire [15:0] sh_avg;
   wire [15:0] bus_avg;

   wire [2:0] mode    = config_reg[`SMCC_MODE_LSB +: 3];
   wire [3:0] s_avg   = config_reg[`SMCC_SAVG_LSB +: 4];
   wire [3:0] b_avg   = config_reg[`SMCC_BAVG_LSB +: 4];
   wire       want_sh  = mode[0];
   wire       want_bus = mode[1];
   wire       off_mode = (mode == `SMCC_MODE_PDOWN) || (mode == `SMCC_MODE_ADC_OFF);
   wire       cont     = mode[2] && !off_mode;

   // apb access decode
   wire acc_phase = psel && penable && pready;
   wire wr_en     = acc_phase && pwrite;
   wire rd_en     = acc_phase && !pwrite;
   wire cfg_wr    = wr_en && (paddr == `SMCC_OFS_CONFIG);
   wire cal_wr    = wr_en && (paddr == `SMCC_OFS_CALIB);
   wire [2:0] wmode = pwdata[`SMCC_MODE_LSB +: 3];
   wire trig_wr   = cfg_wr && !wmode[2] && (wmode != `SMCC_MODE_PDOWN);
   wire stat_rd   = rd_en && (paddr == `SMCC_OFS_STATUS);

   // convert pin through two flops; the second and a third edge-detect flop both feed logic
   wire conv_rise = conv_sync2 && !conv_last;
   wire pin_trig  = conv_rise && !mode[2] && !off_mode;

   // current and power arithmetic, one sequencer state each after sampling
   wire signed [32:0] cur_prod = $signed(shunt_res) * $signed({1'b0, calib});
   wire signed [32:0] cur_q    = cur_prod >>> `SMCC_CURR_SHIFT;
   wire signed [32:0] pwr_prod = $signed(cur_prod_hold) * $signed({17'h00000, bus_res[15:3]});
   wire signed [32:0] pwr_abs  = pwr_prod[32] ? -pwr_prod : pwr_prod;
   wire        [32:0] pwr_q    = $unsigned(pwr_abs) / 33'd5000;

   // ---------------------------------------------------------
   // averaging engines, one per channel, each with its own setting
   // ---------------------------------------------------------
   smcc_avg #(.W(16)) u_avg_shunt (
      .pclk      (pclk),
      .presetn   (presetn),
      .start     (avg_start_sh),
      .avg_sel   (s_avg),
      .smp_valid (smp_valid && smp_req_shunt),
      .smp_data  (smp_shunt),
      .done      (sh_done),
      .result    (sh_avg)
   );
   smcc_avg #(.W(16)) u_avg_bus (
      .pclk      (pclk),
      .presetn   (presetn),
      .start     (avg_start_bus),
      .avg_sel   (b_avg),
      .smp_valid (smp_valid && smp_req_bus),
      .smp_data  (smp_bus),
      .done      (bus_done),
      .result    (bus_avg)
   );

   // ---------------------------------------------------------
   // register writes and pin synchroniser
   // ---------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_reg     <= `SMCC_CONFIG_RESET;
         calib          <= 16'h0000;
         conv_sync1     <= 1'b0;
         conv_sync2     <= 1'b0;
         conv_last      <= 1'b0;
         shunt_gain_sel <= 2'h3;
         bus_range_sel  <= 1'b1;
      end else begin
         conv_sync1 <= convert_pin;
         conv_sync2 <= conv_sync1;
         conv_last  <= conv_sync2;
         if (cfg_wr)
            config_reg <= pwdata[15:0] & `SMCC_CONFIG_MASK;
         if (cal_wr)
            calib <= {pwdata[15:1], 1'b0};
         shunt_gain_sel <= config_reg[`SMCC_GAIN_LSB +: 2];
         bus_range_sel  <= config_reg[`SMCC_BUS_RANGE_SEL_BIT];
      end
   end

   // ---------------------------------------------------------
   // conversion sequencer
   // ---------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= ST_IDLE;
         wake_cnt      <= 13'h0000;
         shot_pending  <= 1'b0;
         avg_start_sh  <= 1'b0;
         avg_start_bus <= 1'b0;
         smp_req_shunt <= 1'b0;
         smp_req_bus   <= 1'b0;
         shunt_res     <= 16'h0000;
         bus_res       <= 16'h0000;
         current_res   <= 16'h0000;
         power_res     <= 16'h0000;
         cur_prod_hold <= 16'h0000;
         math_ovf      <= 1'b0;
         adc_power_on  <= 1'b1;
      end else begin
         avg_start_sh  <= 1'b0;
         avg_start_bus <= 1'b0;
         if (trig_wr || pin_trig)
            shot_pending <= 1'b1;
         adc_power_on <= (mode != `SMCC_MODE_PDOWN);
         // any write that leaves power-down waits out the settle time,
         // so a converting mode never starts on an unsettled front end
         if (cfg_wr && (mode == `SMCC_MODE_PDOWN) && (wmode != `SMCC_MODE_PDOWN)) begin
            state    <= ST_WAKE;
            wake_cnt <= 13'h0000;
         end else if (off_mode && !(state == ST_WAKE)) begin
            state         <= ST_IDLE;
            smp_req_shunt <= 1'b0;
            smp_req_bus   <= 1'b0;
         end else begin
            case (state)
               ST_WAKE: begin
                  // conversions stay parked until the front end has settled
                  if (wake_cnt >= WAKE_LAST)
                     state <= ST_IDLE;
                  else
                     wake_cnt <= wake_cnt + 13'h0001;
               end
               ST_IDLE: begin
                  if (!off_mode && (cont || shot_pending)) begin
                     // a trigger landing in the launch cycle queues the next shot
                     shot_pending <= trig_wr || pin_trig;
                     if (want_sh) begin
                        state         <= ST_SHUNT;
                        avg_start_sh  <= 1'b1;
                        smp_req_shunt <= 1'b1;
                     end else begin
                        state         <= ST_BUS;
                        avg_start_bus <= 1'b1;
                        smp_req_bus   <= 1'b1;
                     end
                  end
               end
               ST_SHUNT: begin
                  if (sh_done) begin
                     shunt_res     <= sh_avg;
                     smp_req_shunt <= 1'b0;
                     if (want_bus) begin
                        state         <= ST_BUS;
                        avg_start_bus <= 1'b1;
                        smp_req_bus   <= 1'b1;
                     end else
                        state <= ST_MATH1;
                  end
               end
               ST_BUS: begin
                  if (bus_done) begin
                     bus_res     <= {bus_avg[12:0], 3'h0};
                     smp_req_bus <= 1'b0;
                     state       <= ST_MATH1;
                  end
               end
               ST_MATH1: begin
                  cur_prod_hold <= (calib == 16'h0000) ? 16'h0000 : cur_q[15:0];
                  state         <= ST_MATH2;
               end
               ST_MATH2: begin
                  current_res <= cur_prod_hold;
                  power_res   <= (calib == 16'h0000) ? 16'h0000 : pwr_q[15:0];
                  math_ovf    <= (pwr_q[32:16] != 17'h00000);
                  state       <= ST_IDLE;
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------------------
   // ready flag: a completion in the clearing cycle wins
   // ---------------------------------------------------------
   wire ready_set = (state == ST_MATH2);
   wire ready_clr = (cfg_wr && !((wmode == `SMCC_MODE_PDOWN) || (wmode == `SMCC_MODE_ADC_OFF)))
                    || stat_rd || pin_trig;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         conversion_ready_flag <= 1'b0;
      else if (ready_set)
         conversion_ready_flag <= 1'b1;
      else if (ready_clr)
         conversion_ready_flag <= 1'b0;
   end

   // ---------------------------------------------------------
   // apb slave: no wait states, readback registered
   // ---------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h00000000;
            case (paddr)
               `SMCC_OFS_CONFIG:  prdata <= {16'h0000, config_reg};
               `SMCC_OFS_SHUNT:   prdata <= {16'h0000, shunt_res};
               `SMCC_OFS_BUS:     prdata <= {16'h0000, bus_res};
               `SMCC_OFS_POWER:   prdata <= {16'h0000, power_res};
               `SMCC_OFS_CURRENT: prdata <= {16'h0000, current_res};
               `SMCC_OFS_CALIB:   prdata <= {16'h0000, calib};
               `SMCC_OFS_STATUS:  prdata <= {29'h00000000, (state != ST_IDLE),
                                             conversion_ready_flag, math_ovf};
               `SMCC_OFS_SAMPLE:  prdata <= 32'h00000000;
               default:           pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule // smcc_ctrl
`default_nettype wire

// *** smcc_consts.vh ***
// constants for the shunt monitor conversion controller
`ifndef SMCC_CONSTS_VH
`define SMCC_CONSTS_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SMCC_OFS_CONFIG     12'h000
`define SMCC_OFS_SHUNT      12'h004
`define SMCC_OFS_BUS        12'h008
`define SMCC_OFS_POWER      12'h00c
`define SMCC_OFS_CURRENT    12'h010
`define SMCC_OFS_CALIB      12'h014
`define SMCC_OFS_STATUS     12'h018
`define SMCC_OFS_SAMPLE     12'h01c
// ------------------------------------------------------------
// configuration fields
// ------------------------------------------------------------
`define SMCC_MODE_LSB       0
`define SMCC_SAVG_LSB       3
`define SMCC_BAVG_LSB       7
`define SMCC_GAIN_LSB       11
`define SMCC_BUS_RANGE_SEL_BIT       13
`define SMCC_CONFIG_RESET   16'h399f
`define SMCC_CONFIG_MASK    16'h3fff
// ------------------------------------------------------------
// mode codes
// ------------------------------------------------------------
`define SMCC_MODE_PDOWN     3'h0
`define SMCC_MODE_TRIG_SH   3'h1
`define SMCC_MODE_TRIG_BUS  3'h2
`define SMCC_MODE_TRIG_BOTH 3'h3
`define SMCC_MODE_ADC_OFF   3'h4
`define SMCC_MODE_CONT_SH   3'h5
`define SMCC_MODE_CONT_BUS  3'h6
`define SMCC_MODE_CONT_BOTH 3'h7
// ------------------------------------------------------------
// status bits and timing
// ------------------------------------------------------------
`define SMCC_STAT_READY_BIT 1
`define SMCC_STAT_OVF_BIT   0
`define SMCC_STAT_BUSY_BIT  2
`define SMCC_RECOVER_US     40
`define SMCC_CLK_MHZ        100
`define SMCC_RECOVER_CYC    (`SMCC_RECOVER_US * `SMCC_CLK_MHZ)
`define SMCC_CURR_SHIFT     12
`define SMCC_POWER_DIV      5000
`endif

// *** smcc_avg.v ***
// sample accumulator that averages a programmable number of samples
`timescale 1ns/1ps
`default_nettype none
module smcc_avg #(
   parameter W = 16
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          start,
   input  wire [3:0]    avg_sel,
   input  wire          smp_valid,
   input  wire [W-1:0]  smp_data,
   output reg           done,
   output reg  [W-1:0]  result
);
   reg         active;
   reg [7:0]   count;
   reg [W+6:0] acc;
   wire [2:0]  log_n = avg_sel[3] ? avg_sel[2:0] : 3'h0;
   wire [W+6:0] next_acc = acc + {{7{smp_data[W-1]}}, smp_data};
   wire signed [W+6:0] avg_shift = $signed(next_acc) >>> log_n;
   // ---------------------------------------------------------
   // accumulate 2**log_n samples, then shift down arithmetically
   // ---------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 1'b0;
         count  <= 8'h00;
         acc    <= {(W+7){1'b0}};
         done   <= 1'b0;
         result <= {W{1'b0}};
      end else begin
         done <= 1'b0;
         if (start) begin
            active <= 1'b1;
            count  <= 8'h00;
            acc    <= {(W+7){1'b0}};
         end else if (active && smp_valid) begin
            acc   <= next_acc;
            count <= count + 8'h01;
            if (count == ((8'h01 << log_n) - 8'h01)) begin
               active <= 1'b0;
               done   <= 1'b1;
               result <= avg_shift[W-1:0];
            end
         end
      end
   end
endmodule // smcc_avg
`default_nettype wire

// *** smcc_ctrl_properties.sv ***
// port assertions for the shunt monitor conversion controller
`timescale 1ns/1ps
`default_nettype none
`include "smcc_consts.vh"
module smcc_ctrl_properties #(
   parameter RECOVER_CYC = 10
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        convert_pin,
   input wire logic        smp_valid,
   input wire logic [15:0] smp_shunt,
   input wire logic [15:0] smp_bus,
   input wire logic        smp_req_shunt,
   input wire logic        smp_req_bus,
   input wire logic [1:0]  shunt_gain_sel,
   input wire logic        bus_range_sel,
   input wire logic        conversion_ready_flag,
   input wire logic        adc_power_on
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // decoded bus events and controller status
   // ------------------------------------------------------------
   wire setup = psel && !penable;
   wire acc   = psel && penable && pready;
   wire cfg_w = acc && pwrite && paddr == `SMCC_OFS_CONFIG;
   wire off_c = pwdata[2:0] == `SMCC_MODE_PDOWN || pwdata[2:0] == `SMCC_MODE_ADC_OFF;
   wire idle  = !smp_req_shunt && !smp_req_bus;
   wire rdy   = conversion_ready_flag;
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_answer; setup |=> pready; endproperty
   property p_unmapped;
      setup && paddr > `SMCC_OFS_SAMPLE |=> pslverr && (pwrite || prdata == 32'h0);
   endproperty
   property p_cfg_clear; cfg_w && !off_c |=> !rdy; endproperty
   property p_off_keep; cfg_w && off_c && rdy |=> rdy; endproperty
   property p_stat_clear; acc && !pwrite && paddr == `SMCC_OFS_STATUS |=> !rdy; endproperty
   property p_pin_clear; $rose(convert_pin) |-> ##[2:5] !rdy; endproperty
   property p_rdy_after; $rose(rdy) |-> $past(idle) && $past(idle, 2); endproperty
   property p_pdown; !adc_power_on && !$past(adc_power_on) |-> idle; endproperty
   property p_one_chan; !(smp_req_shunt && smp_req_bus); endproperty
   a_answer:     assert property (p_answer) else $error("no pready after setup");
   a_unmapped:   assert property (p_unmapped) else $error("unmapped access not refused");
   a_cfg_clear:  assert property (p_cfg_clear) else $error("config write kept ready");
   a_off_keep:   assert property (p_off_keep) else $error("off write cleared ready");
   a_stat_clear: assert property (p_stat_clear) else $error("status read kept ready");
   a_pin_clear:  assert property (p_pin_clear) else $error("pin trigger kept ready");
   a_rdy_after:  assert property (p_rdy_after) else $error("ready before math done");
   a_pdown:      assert property (p_pdown) else $error("sampling in power down");
   a_one_chan:   assert property (p_one_chan) else $error("both channels requested");
   // main scenarios reached
   c_cfg:  cover property (cfg_w && !off_c);
   c_rdy:  cover property ($rose(rdy));
   c_pin:  cover property ($rose(convert_pin));
   c_stat: cover property (acc && paddr == `SMCC_OFS_STATUS);
endmodule // smcc_ctrl_properties
bind smcc_ctrl smcc_ctrl_properties #(.RECOVER_CYC(RECOVER_CYC)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .convert_pin(convert_pin), .smp_valid(smp_valid), .smp_shunt(smp_shunt),
   .smp_bus(smp_bus), .smp_req_shunt(smp_req_shunt), .smp_req_bus(smp_req_bus),
   .shunt_gain_sel(shunt_gain_sel), .bus_range_sel(bus_range_sel),
   .conversion_ready_flag(conversion_ready_flag), .adc_power_on(adc_power_on));
`default_nettype wire

// *** smcc_adc_model.sv ***
// sample source model standing in for the converter front end
`timescale 1ns/1ps
`default_nettype none
module smcc_adc_model #(
   parameter logic [15:0] SHUNT_V = 16'h1000,
   parameter logic [15:0] BUS_V   = 16'h0fa0
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        req_shunt,
   input  wire logic        req_bus,
   input  wire logic        power_on,
   output var  logic        smp_valid,
   output wire logic [15:0] smp_shunt,
   output wire logic [15:0] smp_bus
);
   logic [1:0] tick;
   // one sample every fourth cycle while asked, so waits are never trivial
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick <= 2'h0;
         smp_valid <= 1'b0;
      end else begin
         tick <= ((req_shunt || req_bus) && power_on) ? tick + 2'h1 : 2'h0;
         smp_valid <= tick == 2'h3 && (req_shunt || req_bus);
      end
   end
   // inverse between samples: a read outside valid shows up as a wrong value
   assign smp_shunt = smp_valid ? SHUNT_V : ~SHUNT_V;
   assign smp_bus   = smp_valid ? BUS_V : ~BUS_V;
endmodule // smcc_adc_model
`default_nettype wire

// *** smcc_ctrl_test.sv ***
// self-checking testbench of the conversion controller
`timescale 1ns/1ps
`default_nettype none
`include "smcc_consts.vh"
module smcc_ctrl_test;
   localparam int RCYC = 10;
   localparam logic [31:0] SHV = 32'h1000;
   localparam logic [31:0] BUSV = 32'h0fa0;
   localparam logic [31:0] CAL = 32'h2000;
   localparam logic [31:0] ECUR = (SHV * CAL) >> 12;
   localparam logic [31:0] EPWR = ECUR * BUSV / `SMCC_POWER_DIV;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, convert_pin = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic rerr, seen_sh, seen_bu;
   wire logic [31:0] prdata;
   wire logic [15:0] smp_shunt, smp_bus;
   wire logic [1:0] shunt_gain_sel;
   wire logic pready, pslverr, smp_valid, smp_req_shunt, smp_req_bus;
   wire logic bus_range_sel, conversion_ready_flag, adc_power_on;
   int err_count = 0;
   int samples_checked = 0;
   int nsmp;
   smcc_ctrl #(.RECOVER_CYC(RCYC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .convert_pin(convert_pin), .smp_valid(smp_valid),
      .smp_shunt(smp_shunt), .smp_bus(smp_bus), .smp_req_shunt(smp_req_shunt),
      .smp_req_bus(smp_req_bus), .shunt_gain_sel(shunt_gain_sel),
      .bus_range_sel(bus_range_sel), .conversion_ready_flag(conversion_ready_flag),
      .adc_power_on(adc_power_on));
   smcc_adc_model #(.SHUNT_V(SHV[15:0]), .BUS_V(BUSV[15:0])) u_adc (.pclk(pclk),
      .presetn(presetn), .req_shunt(smp_req_shunt), .req_bus(smp_req_bus),
      .power_on(adc_power_on), .smp_valid(smp_valid), .smp_shunt(smp_shunt),
      .smp_bus(smp_bus));
   initial forever #5 pclk = ~pclk;
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask
   task automatic flag_is(input logic v);
      @(negedge pclk);
      chk("ready flag", conversion_ready_flag, v);
   endtask
   // bounded wait for ready, noting which channels were sampled
   task automatic wait_rdy;
      int n;
      n = 0;
      nsmp = 0;
      seen_sh = 0;
      seen_bu = 0;
      while (conversion_ready_flag !== 1'b1 && n < 500) begin
         @(posedge pclk);
         seen_sh |= smp_req_shunt;
         seen_bu |= smp_req_bus;
         nsmp += smp_valid;
         n++;
      end
      chk("ready wait", conversion_ready_flag, 1);
      if (conversion_ready_flag !== 1'b1)
         end_sim;
   endtask
   task automatic quiet(input int n);
      logic bad;
      bad = 0;
      repeat (n) @(posedge pclk) bad |= smp_req_shunt | smp_req_bus;
      chk("no sampling", bad, 0);
   endtask
   task automatic pin_pulse;
      @(posedge pclk);
      convert_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      convert_pin <= 1'b0;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk("ready flag", conversion_ready_flag, 0);
      chk("gain", shunt_gain_sel, 3);
      chk("range", bus_range_sel, 1);
      rdc("config", `SMCC_OFS_CONFIG, `SMCC_CONFIG_RESET);
      wait_rdy;
      rdc("current", `SMCC_OFS_CURRENT, 0);
      rdc("power", `SMCC_OFS_POWER, 0);
      $display("t_reset done");
   endtask
   task automatic t_cont;
      wr(`SMCC_OFS_CONFIG, 32'h399c); // stop first so the restart cannot meet a set
      repeat (20) @(posedge pclk);
      wr(`SMCC_OFS_CALIB, CAL);
      wr(`SMCC_OFS_CONFIG, `SMCC_CONFIG_RESET);
      flag_is(0);
      wait_rdy;
      chk("both sampled", {seen_sh, seen_bu}, 2'b11);
      rdc("shunt", `SMCC_OFS_SHUNT, SHV);
      rdc("current", `SMCC_OFS_CURRENT, ECUR);
      rdc("power", `SMCC_OFS_POWER, EPWR);
      rdc("bus", `SMCC_OFS_BUS, BUSV << 3);
      chk("bus value", rd >> 3, BUSV);
      $display("t_cont done");
   endtask
   task automatic t_off;
      wr(`SMCC_OFS_CONFIG, 32'h399c);
      flag_is(1);
      @(posedge pclk); // requests drop one edge after the mode lands
      quiet(40);
      rdc("shunt held", `SMCC_OFS_SHUNT, SHV);
      wr(`SMCC_OFS_CONFIG, 32'h3998);
      flag_is(1);
      @(negedge pclk); // power follows the stored mode one edge later
      chk("power on", adc_power_on, 0);
      quiet(20);
      wr(`SMCC_OFS_CONFIG, 32'h399e); // leave power-down into continuous bus only
      quiet(RCYC);
      chk("power on", adc_power_on, 1);
      wait_rdy;
      chk("bus only", {seen_sh, seen_bu}, 2'b01);
      wr(`SMCC_OFS_CONFIG, 32'h399c);
      $display("t_off done");
   endtask
   // each triggered code written twice: a repeat write must still fire
   task automatic t_trig;
      for (int m = 1; m < 4; m++) begin
         for (int k = 0; k < 2; k++) begin
            wr(`SMCC_OFS_CONFIG, 32'h35d0 | m);
            flag_is(0);
            wait_rdy;
            chk("shunt req", seen_sh, m[0]);
            chk("bus req", seen_bu, m[1]);
            chk("samples", nsmp, 4 * m[0] + 8 * m[1]);
            quiet(30);
            rdc("shunt", `SMCC_OFS_SHUNT, SHV);
            rdc("status", `SMCC_OFS_STATUS, 32'h2);
            flag_is(0);
         end
      end
      $display("t_trig done");
   endtask
   task automatic t_pin;
      pin_pulse;
      wait_rdy;
      pin_pulse;
      flag_is(0);
      wait_rdy;
      $display("t_pin done");
   endtask
   // gain and bus averaging follow the loop count, range its low bit, shunt averaging runs the other way
   task automatic t_gain;
      logic [31:0] v;
      for (int g = 0; g < 4; g++) begin
         v = (g[0] << 13) | (g << 11) | (g << 7) | ((15 - g) << 3) | 4;
         wr(`SMCC_OFS_CONFIG, v);
         repeat (2) @(negedge pclk);
         chk("gain", shunt_gain_sel, g);
         chk("range", bus_range_sel, g & 1);
         rdc("config", `SMCC_OFS_CONFIG, v);
      end
      $display("t_gain done");
   endtask
   task automatic t_unmap;
      apb(1'b0, 12'h020, 32'h0);
      chk("slverr", rerr, 1);
      chk("unmapped data", rd, 0);
      apb(1'b1, 12'h020, 32'hffff);
      chk("slverr", rerr, 1);
      rdc("reserved", `SMCC_OFS_SAMPLE, 0);
      chk("slverr", rerr, 0);
      rdc("calib", `SMCC_OFS_CALIB, CAL);
      $display("t_unmap done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_cont;
      t_off;
      t_trig;
      t_pin;
      t_gain;
      t_unmap;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      end_sim;
   end
endmodule // smcc_ctrl_test
`default_nettype wire
